//--- apsf_pkg.sv
package apsf_pkg;
	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int ACC_W = 16;
	localparam int ACC_COUNT = 4;
	localparam int INDEX_W = 2;

	// Register offsets
	localparam logic [3:0] OFF_INDEX = 4'h0;
	localparam logic [3:0] OFF_CTRL = 4'h1;
	localparam logic [3:0] OFF_STATUS = 4'h4;

	// Index step control fields
	localparam int CTRL_WRAP_LO = 0;
	localparam int CTRL_WRAP_HI = 1;
	localparam int CTRL_RSVD_LO = 2;
	localparam int CTRL_RSVD_HI = 5;
	localparam int CTRL_STEP_DOWN = 6;
	localparam int CTRL_WIPE = 7;

	// Status flag fields
	localparam int ST_MATCH = 0;
	localparam int ST_CARRY = 1;
	localparam int ST_SIGNED_WRAP = 2;
	localparam int ST_USER0 = 3;
	localparam int ST_USER1 = 4;
	localparam int ST_RSVD = 5;
	localparam int ST_SIGN = 6;
	localparam int ST_NULL = 7;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h80;
	localparam logic [1:0] INDEX_RST = 2'h0;
	localparam logic [15:0] ACC_RST = 16'h0000;

	typedef enum logic [1:0] {
		WRAP_NONE = 2'b00,
		WRAP_MOD2 = 2'b01,
		WRAP_MOD4 = 2'b10,
		WRAP_RSVD = 2'b11
	} apsf_wrap_t;
endpackage : apsf_pkg

//--- apsf_step.sv
`timescale 1ns/1ps
`default_nettype none
module apsf_step
	import apsf_pkg::*;
(
	input wire logic [1:0] index,
	input wire logic [1:0] wrap_size,
	input wire logic step_down,
	output logic [1:0] stepped
);
	always_comb begin
		unique case (apsf_wrap_t'(wrap_size))
			WRAP_NONE: stepped = index;
			// Up or down by one modulo 2 both toggle the low bit only
			WRAP_MOD2: stepped = {index[1], ~index[0]};
			WRAP_MOD4, WRAP_RSVD: stepped = step_down ? index - 2'h1 : index + 2'h1;
		endcase
	end
endmodule : apsf_step
`default_nettype wire

//--- apsf_acc_bank.sv
`timescale 1ns/1ps
`default_nettype none
module apsf_acc_bank
	import apsf_pkg::*;
#(
	parameter int WIDTH = ACC_W,
	parameter int DEPTH = ACC_COUNT
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata_q,
	output logic null_q
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rd_val;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_entry
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					mem_q[gi] <= WIDTH'(ACC_RST);
				end else if (we && waddr == gi) begin
					mem_q[gi] <= wdata;
				end
			end
		end
	endgenerate

	// Write-through so the registered view never lags a fresh result
	always_comb begin
		rd_val = (we && waddr == raddr) ? wdata : mem_q[raddr];
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= WIDTH'(ACC_RST);
			null_q <= 1'b1;
		end else begin
			rdata_q <= rd_val;
			null_q <= ~|rd_val;
		end
	end
endmodule : apsf_acc_bank
`default_nettype wire

//--- apsf_core.sv
// Notes on behaviour
// - The 2-bit working index picks which of four accumulators is active.
// - Wrap size 00 leaves the index unchanged after operations; this is the default.
// - Wrap size 01 steps modulo 2; 10 and reserved 11 step modulo 4.
// - Control bits five down to two read as zero.
// - Step down clear with stepping active: index increments after each operation.
// - Step down set with stepping active: index decrements after each operation.
// - Setting the index wipe bit clears the working index to zero.
// - The index wipe bit returns to zero by itself after the clear.
// - A control write setting index wipe suppresses that instruction's automatic step.
// - Status flags load 80h on every reset.
// - Status reads are free; writes change only wrap, match, carry and user bits.
// - Each compare sets match when values are equal, clears it otherwise.
// - Software writing 1 to match sets it.
// - Add-out follows the carry or borrow of the last operation.
// - Software writing 1 to add-out sets it.
// - Null bit is NOR of the active accumulator, following operations and selection.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module apsf_core
	import apsf_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int XW = ACC_W
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	input wire logic op_done,
	input wire logic op_carry,
	input wire logic op_signed_wrap,
	input wire logic cmp_done,
	input wire logic cmp_equal,
	input wire logic acc_wr,
	input wire logic [XW-1:0] acc_wr_data,
	output logic [1:0] working_acc_index,
	output logic [XW-1:0] active_acc,
	output logic match_flag,
	output logic carry_flag,
	output logic null_flag
);
	logic [1:0] index_q;
	logic [1:0] index_d;
	logic [1:0] stepped;
	logic [1:0] wrap_size_q;
	logic step_down_q;
	logic index_wipe_q;
	logic match_q;
	logic carry_q;
	logic signed_wrap_q;
	logic user_bit_0_q;
	logic user_bit_1_q;
	logic [DW-1:0] reg_rdata_q;
	logic [XW-1:0] bank_rdata;
	logic bank_null;

	logic index_wr;
	logic ctrl_wr;
	logic status_wr;
	logic wipe_req;
	logic [DW-1:0] ctrl_view;
	logic [DW-1:0] status_view;

	always_comb begin
		index_wr = reg_wr && reg_addr == OFF_INDEX;
		ctrl_wr = reg_wr && reg_addr == OFF_CTRL;
		status_wr = reg_wr && reg_addr == OFF_STATUS;
		wipe_req = ctrl_wr && reg_wdata[CTRL_WIPE];
	end

	// Next step of the working index under the current wrap setting
	apsf_step u_step (
		.index(index_q),
		.wrap_size(wrap_size_q),
		.step_down(step_down_q),
		.stepped(stepped)
	);

	// Wipe first, then a direct index write, then the automatic step
	always_comb begin
		if (wipe_req) begin
			index_d = INDEX_RST;
		end else if (index_wr) begin
			index_d = reg_wdata[1:0];
		end else if (op_done) begin
			index_d = stepped;
		end else begin
			index_d = index_q;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			index_q <= INDEX_RST;
		end else begin
			index_q <= index_d;
		end
	end

	// Reading with the next index keeps the active view aligned with index_q
	apsf_acc_bank #(
		.WIDTH(XW),
		.DEPTH(ACC_COUNT)
	) u_bank (
		.clock(clock),
		.nrst(nrst),
		.we(acc_wr),
		.waddr(index_q),
		.wdata(acc_wr_data),
		.raddr(index_d),
		.rdata_q(bank_rdata),
		.null_q(bank_null)
	);

	// Index step control
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wrap_size_q <= CTRL_RST[CTRL_WRAP_HI:CTRL_WRAP_LO];
			step_down_q <= CTRL_RST[CTRL_STEP_DOWN];
		end else if (ctrl_wr) begin
			wrap_size_q <= reg_wdata[CTRL_WRAP_HI:CTRL_WRAP_LO];
			step_down_q <= reg_wdata[CTRL_STEP_DOWN];
		end
	end

	// Wipe bit is visible for one cycle only, then drops by itself
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			index_wipe_q <= CTRL_RST[CTRL_WIPE];
		end else begin
			index_wipe_q <= wipe_req;
		end
	end

	// Match flag: a compare beats a software write in the same cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			match_q <= STATUS_RST[ST_MATCH];
		end else if (cmp_done) begin
			match_q <= cmp_equal;
		end else if (status_wr) begin
			match_q <= reg_wdata[ST_MATCH];
		end
	end

	// Carry and signed wrap follow operations, which beat software writes
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			carry_q <= STATUS_RST[ST_CARRY];
			signed_wrap_q <= STATUS_RST[ST_SIGNED_WRAP];
		end else if (op_done) begin
			carry_q <= op_carry;
			signed_wrap_q <= op_signed_wrap;
		end else if (status_wr) begin
			carry_q <= reg_wdata[ST_CARRY];
			signed_wrap_q <= reg_wdata[ST_SIGNED_WRAP];
		end
	end

	// User bits are software-only
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			user_bit_0_q <= STATUS_RST[ST_USER0];
			user_bit_1_q <= STATUS_RST[ST_USER1];
		end else if (status_wr) begin
			user_bit_0_q <= reg_wdata[ST_USER0];
			user_bit_1_q <= reg_wdata[ST_USER1];
		end
	end

	always_comb begin
		ctrl_view = '0;
		ctrl_view[CTRL_WRAP_HI:CTRL_WRAP_LO] = wrap_size_q;
		ctrl_view[CTRL_RSVD_HI:CTRL_RSVD_LO] = 4'h0;
		ctrl_view[CTRL_STEP_DOWN] = step_down_q;
		ctrl_view[CTRL_WIPE] = index_wipe_q;
	end

	// Sign and null come from the active accumulator, never from writes
	always_comb begin
		status_view = '0;
		status_view[ST_MATCH] = match_q;
		status_view[ST_CARRY] = carry_q;
		status_view[ST_SIGNED_WRAP] = signed_wrap_q;
		status_view[ST_USER0] = user_bit_0_q;
		status_view[ST_USER1] = user_bit_1_q;
		status_view[ST_RSVD] = 1'b0;
		status_view[ST_SIGN] = bank_rdata[XW-1];
		status_view[ST_NULL] = bank_null;
	end

	// Read data stand for one cycle after the strobe, zero otherwise
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFF_INDEX: reg_rdata_q <= {{(DW-2){1'b0}}, index_q};
				OFF_CTRL: reg_rdata_q <= ctrl_view;
				OFF_STATUS: reg_rdata_q <= status_view;
				default: reg_rdata_q <= '0;
			endcase
		end else begin
			reg_rdata_q <= '0;
		end
	end

	assign reg_rdata = reg_rdata_q;
	assign working_acc_index = index_q;
	assign active_acc = bank_rdata;
	assign match_flag = match_q;
	assign carry_flag = carry_q;
	assign null_flag = bank_null;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	logic plain_step;
	assign plain_step = op_done && !wipe_req && !index_wr;

	a_wipe_clears_index: assert property (
		wipe_req |=> index_q == 2'h0)
		else $error("index not cleared by wipe");

	// The bit may only stay up when a second wipe follows straight away
	a_wipe_self_clear: assert property (
		wipe_req |=> index_wipe_q ##1 (!index_wipe_q || $past(wipe_req)))
		else $error("wipe bit did not drop by itself");

	a_wipe_beats_step: assert property (
		(wipe_req && op_done && wrap_size_q != WRAP_NONE) |=> index_q == 2'h0)
		else $error("step happened despite wipe");

	a_no_wrap_hold: assert property (
		(plain_step && wrap_size_q == WRAP_NONE) |=> $stable(index_q))
		else $error("index moved with wrap size zero");

	a_index_hold: assert property (
		(!wipe_req && !index_wr && !op_done) |=> $stable(index_q))
		else $error("index moved without an event");

	a_index_read: assert property (
		(reg_rd && reg_addr == OFF_INDEX) |=>
		(reg_rdata[DW-1:2] == '0) && (reg_rdata[1:0] == $past(index_q)))
		else $error("index read wrong");

	a_ctrl_write: assert property (
		ctrl_wr |=> (wrap_size_q == $past(reg_wdata[CTRL_WRAP_HI:CTRL_WRAP_LO]))
		&& (step_down_q == $past(reg_wdata[CTRL_STEP_DOWN])))
		else $error("control write did not land");

	a_mod2_low_bit: assert property (
		(plain_step && wrap_size_q == WRAP_MOD2) |=>
		(index_q[1] == $past(index_q[1])) && (index_q[0] != $past(index_q[0])))
		else $error("modulo 2 step wrong");

	a_mod4_step_up: assert property (
		(plain_step && wrap_size_q[1] && !step_down_q) |=> index_q == $past(index_q) + 2'h1)
		else $error("increment step wrong");

	a_mod4_step_down: assert property (
		(plain_step && wrap_size_q[1] && step_down_q) |=> index_q == $past(index_q) - 2'h1)
		else $error("decrement step wrong");

	// Reserved code must carry through both index bits like modulo 4
	a_rsvd_as_mod4: assert property (
		(plain_step && wrap_size_q == WRAP_RSVD) |=>
		index_q == ($past(step_down_q) ? $past(index_q) - 2'h1 : $past(index_q) + 2'h1))
		else $error("reserved wrap did not step modulo 4");

	a_ctrl_rsvd_zero: assert property (
		(reg_rd && reg_addr == OFF_CTRL) |=> reg_rdata_q[CTRL_RSVD_HI:CTRL_RSVD_LO] == 4'h0)
		else $error("control reserved bits not zero");

	a_status_rsvd_zero: assert property (
		(reg_rd && reg_addr == OFF_STATUS) |=>
		(reg_rdata_q[ST_RSVD] == 1'b0) && (reg_rdata_q[ST_NULL] == $past(null_flag)))
		else $error("status read wrong");

	a_fixed_status_bits: assert property (
		(status_wr && !op_done && !acc_wr) |=> $stable(null_flag) && $stable(active_acc))
		else $error("status write touched fixed bits");

	a_wrap_bit_write: assert property (
		(status_wr && !op_done) |=> signed_wrap_q == $past(reg_wdata[ST_SIGNED_WRAP]))
		else $error("signed wrap bit not written");

	a_user_hold: assert property (
		!status_wr |=> $stable(user_bit_0_q) && $stable(user_bit_1_q))
		else $error("user bits moved without a write");

	a_user_write: assert property (
		status_wr |=> (user_bit_0_q == $past(reg_wdata[ST_USER0]))
		&& (user_bit_1_q == $past(reg_wdata[ST_USER1])))
		else $error("user bits not written");

	a_match_compare: assert property (
		cmp_done |=> match_flag == $past(cmp_equal))
		else $error("match flag does not follow compare");

	a_match_hold: assert property (
		(!cmp_done && !status_wr) |=> $stable(match_flag))
		else $error("match flag moved without a compare");

	a_match_write: assert property (
		(status_wr && reg_wdata[ST_MATCH] && !cmp_done) |=> match_flag)
		else $error("match flag not set by write");

	a_carry_op: assert property (
		op_done |=> carry_flag == $past(op_carry))
		else $error("carry flag does not follow operation");

	a_carry_hold: assert property (
		(!op_done && !status_wr) |=> $stable(carry_flag))
		else $error("carry flag moved without an operation");

	a_carry_write: assert property (
		(status_wr && reg_wdata[ST_CARRY] && !op_done) |=> carry_flag)
		else $error("carry flag not set by write");

	a_null_nor: assert property (
		null_flag == ~|active_acc)
		else $error("null flag is not NOR of active accumulator");

	a_active_write: assert property (
		(acc_wr && !wipe_req && !index_wr && !op_done) |=>
		(active_acc == $past(acc_wr_data)) && $stable(index_q))
		else $error("active accumulator not written at index");

	a_read_one_cycle: assert property (
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside read cycle");
endmodule : apsf_core
`default_nettype wire

//--- apsf_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module apsf_core_tb_top
	import apsf_pkg::*;
;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic op_done = 1'b0;
	logic op_carry = 1'b0;
	logic op_signed_wrap = 1'b0;
	logic cmp_done = 1'b0;
	logic cmp_equal = 1'b0;
	logic acc_wr = 1'b0;
	logic [15:0] acc_wr_data = 16'h0000;
	logic [1:0] working_acc_index;
	logic [15:0] active_acc;
	logic match_flag;
	logic carry_flag;
	logic null_flag;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;

	apsf_core dut (
		.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_done(op_done),
		.op_carry(op_carry), .op_signed_wrap(op_signed_wrap), .cmp_done(cmp_done),
		.cmp_equal(cmp_equal), .acc_wr(acc_wr), .acc_wr_data(acc_wr_data),
		.working_acc_index(working_acc_index), .active_acc(active_acc),
		.match_flag(match_flag), .carry_flag(carry_flag), .null_flag(null_flag)
	);

	always #25 clock = ~clock;

	task automatic test_done();
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	always @(posedge clock) begin
		if (++cycles == 5000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand in the cycle after the strobe
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask : rdc

	task automatic op(input logic c);
		@(posedge clock);
		op_done <= 1'b1;
		op_carry <= c;
		op_signed_wrap <= c;
		@(posedge clock);
		op_done <= 1'b0;
		@(negedge clock);
	endtask : op

	task automatic test_reset();
		rdc(OFF_STATUS, 8'h80);
		rdc(OFF_CTRL, 8'h00);
		chk("working_acc_index", 16'h0000, {14'h0, working_acc_index});
		chk("null_flag", 16'h0001, {15'h0, null_flag});
		rdc(4'h7, 8'h00);
		$display("test reset done");
	endtask : test_reset

	task automatic test_step();
		logic [1:0] e;
		for (int m = 0; m < 4; m++) begin
			for (int d = 0; d < 2; d++) begin
				wr(OFF_INDEX, 8'h03);
				wr(OFF_CTRL, {1'b0, d[0], 4'h0, m[1:0]});
				op(1'b0);
				e = (m == 0) ? 2'h3 : (m == 1) ? 2'h2 : (d == 1) ? 2'h2 : 2'h0;
				chk("working_acc_index", {14'h0, e}, {14'h0, working_acc_index});
			end
		end
		wr(OFF_CTRL, 8'h3e);
		rdc(OFF_CTRL, 8'h02);
		$display("test step done");
	endtask : test_step

	task automatic test_wipe();
		wr(OFF_INDEX, 8'h01);
		@(posedge clock);
		reg_addr <= OFF_CTRL;
		reg_wdata <= 8'h82;
		reg_wr <= 1'b1;
		op_done <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		op_done <= 1'b0;
		@(negedge clock);
		chk("working_acc_index", 16'h0000, {14'h0, working_acc_index});
		rdc(OFF_CTRL, 8'h02);
		wr(OFF_CTRL, 8'h00);
		$display("test wipe done");
	endtask : test_wipe

	task automatic test_flags();
		wr(OFF_INDEX, 8'h00);
		wr(OFF_STATUS, 8'hff);
		rdc(OFF_STATUS, 8'h9f);
		chk("match_flag", 16'h0001, {15'h0, match_flag});
		chk("carry_flag", 16'h0001, {15'h0, carry_flag});
		wr(OFF_STATUS, 8'h00);
		rdc(OFF_STATUS, 8'h80);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			cmp_done <= 1'b1;
			cmp_equal <= ~i[0];
			@(posedge clock);
			cmp_done <= 1'b0;
			@(negedge clock);
			chk("match_flag", {15'h0, ~i[0]}, {15'h0, match_flag});
			op(~i[0]);
			chk("carry_flag", {15'h0, ~i[0]}, {15'h0, carry_flag});
			rdc(OFF_STATUS, i[0] ? 8'h80 : 8'h87);
		end
		$display("test flags done");
	endtask : test_flags

	task automatic test_acc();
		@(posedge clock);
		acc_wr <= 1'b1;
		acc_wr_data <= 16'h1234;
		@(posedge clock);
		acc_wr <= 1'b0;
		@(negedge clock);
		chk("active_acc", 16'h1234, active_acc);
		chk("null_flag", 16'h0000, {15'h0, null_flag});
		wr(OFF_INDEX, 8'h01);
		@(negedge clock);
		chk("active_acc", 16'h0000, active_acc);
		chk("null_flag", 16'h0001, {15'h0, null_flag});
		wr(OFF_CTRL, 8'h41);
		op(1'b0);
		chk("active_acc", 16'h1234, active_acc);
		chk("null_flag", 16'h0000, {15'h0, null_flag});
		$display("test acc done");
	endtask : test_acc

	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		test_reset();
		test_step();
		test_wipe();
		test_flags();
		test_acc();
		repeat (2) @(posedge clock);
		test_done();
	end
endmodule : apsf_core_tb_top
`default_nettype wire
